/* File: logic/ampp_port.sv */
`timescale 1ns/1ps
// Function
// - Select pin high makes the four port pins static mode straps.
// - Select pin low turns the four port pins into a serial register port.
// - Each register access is one 16-bit word on serial data in.
// - A transfer starts when chip select falls.
// - Serial data in is sampled on the first 16 serial clock rising edges.
// - Rising edges after the sixteenth are ignored.
// - A transfer ends when chip select returns high.
// - Word order: read flag, address bits 6..0, then data bits 7..0.
// - Read flag low stores the data byte into the addressed register.
// - Read flag high returns the addressed register on serial data out.
// - A read leaves the register unchanged and ignores incoming data bits.
// - Serial data out only pulls low or releases; pull-up gives high.
// - Writing 1 to reset register bit 7 clears all mode registers.
// - The reset bit clears itself after the reset write completes.
// - Software reset briefly signals sleep and leaves every register at 00h.
// - The reset register is write-only; read-back returns nothing of it.
// - Reset register bits 6..0 are ignored.
// - Parallel mode: chip select low two-lane 16-bit, high one-lane 14-bit.
// - Parallel mode: serial clock low 3.5mA, high 1.75mA LVDS current.
// - Parallel mode: serial data in low normal, high sleep.
// - Parallel mode: serial data out high enables internal termination.
`include "ampp_consts.svh"

module ampp_port (
	input  wire logic       i_core_clk,
	input  wire logic       i_reset,
	input  wire logic       i_port_style_select,
	input  wire logic       i_cs_n,
	input  wire logic       i_sck,
	input  wire logic       i_sdi,
	input  wire logic       i_sdo,
	output logic            o_sdo,
	output logic            o_sdo_oe,
	output logic            o_serial_mode,
	output logic            o_two_lane,
	output logic            o_lvds_low_current,
	output logic            o_sleep,
	output logic            o_term_on,
	output logic            o_soft_reset,
	output ampp_pkg::ampp_regs_t o_regs
);
	import ampp_pkg::*;

	ampp_state_s st;
	ampp_state_s next_st;
	logic [4:0]  pins;
	logic        cs_fall;
	logic        cs_rise;
	logic        sck_rise;
	logic [6:0]  cur_addr;

	// Register read decode; the reset register reads as zero since it keeps nothing
	function automatic logic [7:0] ampp_read(input ampp_regs_t regs, input logic [6:0] addr);
		logic [7:0] val;
		val = `AMPP_UNMAPPED_READ;
		case (addr)
			`AMPP_OFS_FORMAT: val = regs[0];
			`AMPP_OFS_OUTPUT: val = regs[1];
			`AMPP_OFS_TP_MSB: val = regs[2];
			`AMPP_OFS_TP_LSB: val = regs[3];
			default:          val = `AMPP_UNMAPPED_READ;
		endcase
		return val;
	endfunction : ampp_read

	// Raw pins gathered into synchroniser slots
	always_comb begin
		pins                = '0;
		pins[`AMPP_PIN_SEL] = i_port_style_select;
		pins[`AMPP_PIN_CS]  = i_cs_n;
		pins[`AMPP_PIN_SCK] = i_sck;
		pins[`AMPP_PIN_SDI] = i_sdi;
		pins[`AMPP_PIN_SDO] = i_sdo;
	end

	// Whole next-state computation in one place
	always_comb begin
		next_st           = st;
		next_st.sync1     = pins;
		next_st.sync2     = st.sync1;
		next_st.sync3     = st.sync2;
		next_st.reset_bit = 1'b0;

		// A level counts only once stages two and three agree, filtering glitches
		for (int i = 0; i < `AMPP_PIN_COUNT; i++) begin
			if (st.sync2[i] == st.sync3[i]) begin
				next_st.filt[i] = st.sync3[i];
			end
		end

		// Link clock is slow (400 ns) against the core clock, so edges are found by sampling
		cs_fall  = st.filt[`AMPP_PIN_CS] & ~next_st.filt[`AMPP_PIN_CS];
		cs_rise  = ~st.filt[`AMPP_PIN_CS] & next_st.filt[`AMPP_PIN_CS];
		sck_rise = ~st.filt[`AMPP_PIN_SCK] & next_st.filt[`AMPP_PIN_SCK];
		cur_addr = st.shift_in[`AMPP_ADDR_MSB:`AMPP_ADDR_LSB];

		next_st.serial_mode = ~next_st.filt[`AMPP_PIN_SEL];

		if (!next_st.serial_mode) begin
			// Strap mode: the port is dormant and never drives the data-out pin
			next_st.phase    = AMPP_IDLE;
			next_st.sdo_pull = 1'b0;
		end else begin
			case (st.phase)
				AMPP_IDLE: begin
					if (cs_fall) begin
						next_st.phase    = AMPP_SHIFT;
						next_st.bit_cnt  = '0;
						next_st.rd       = 1'b0;
						next_st.sdo_pull = 1'b0;
					end
				end
				AMPP_SHIFT: begin
					if (cs_rise) begin
						next_st.phase    = AMPP_IDLE;
						next_st.sdo_pull = 1'b0;
						// Short words are dropped; only a full 16-bit write commits
						if (st.bit_cnt == `AMPP_WORD_BITS && !st.shift_in[`AMPP_RW_POS]) begin
							if (cur_addr == `AMPP_OFS_SOFT_RESET) begin
								// Bits 6..0 of the reset byte play no part
								if (st.shift_in[`AMPP_SOFT_RESET_BIT]) begin
									next_st.regs      = {4{`AMPP_REG_RESET}};
									next_st.reset_bit = 1'b1;
								end
							end else if (cur_addr >= `AMPP_OFS_FORMAT &&
									cur_addr <= `AMPP_OFS_TP_LSB) begin
								next_st.regs[2'(cur_addr - `AMPP_OFS_FORMAT)] =
									st.shift_in[`AMPP_DATA_MSB:`AMPP_DATA_LSB];
							end
						end
					end else if (sck_rise && st.bit_cnt < `AMPP_WORD_BITS) begin
						// MSB-first shift keeps flag, address, data in order
						next_st.shift_in = {st.shift_in[14:0], next_st.filt[`AMPP_PIN_SDI]};
						next_st.bit_cnt  = st.bit_cnt + 5'h01;
						if (st.bit_cnt == `AMPP_ADDR_PHASE_END) begin
							// Address complete: read flag sits at bit 6 before this shift
							next_st.rd = st.shift_in[6];
							if (st.shift_in[6]) begin
								next_st.shift_out = ampp_read(st.regs,
									{st.shift_in[5:0], next_st.filt[`AMPP_PIN_SDI]});
								next_st.sdo_pull  = ~next_st.shift_out[7];
							end
						end else if (st.rd && st.bit_cnt > `AMPP_ADDR_PHASE_END) begin
							// Data bits on a read are shifted in but never committed
							if (st.bit_cnt < `AMPP_LAST_OUT_EDGE) begin
								next_st.shift_out = {st.shift_out[6:0], 1'b0};
								next_st.sdo_pull  = ~st.shift_out[6];
							end else begin
								next_st.sdo_pull  = 1'b0;
							end
						end
					end
				end
				default: begin
					next_st.phase    = AMPP_IDLE;
					next_st.sdo_pull = 1'b0;
				end
			endcase
		end

		// Mode decode: straps in parallel mode, registers in serial mode
		if (!next_st.serial_mode) begin
			next_st.two_lane         = ~next_st.filt[`AMPP_PIN_CS];
			next_st.lvds_low_current = next_st.filt[`AMPP_PIN_SCK];
			next_st.sleep            = next_st.filt[`AMPP_PIN_SDI];
			next_st.term_on          = next_st.filt[`AMPP_PIN_SDO];
		end else begin
			next_st.two_lane         = next_st.regs[1][`AMPP_OUT_MODE_MSB:`AMPP_OUT_MODE_LSB]
				<= `AMPP_MODE_2L_LAST;
			next_st.lvds_low_current = next_st.regs[1][`AMPP_OUT_ILVDS_MSB:`AMPP_OUT_ILVDS_LSB]
				== `AMPP_ILVDS_1P75MA;
			// Sleep is also forced for the cycle of a software reset
			next_st.sleep            = next_st.regs[0][`AMPP_FMT_SLEEP_BIT] |
				next_st.reset_bit;
			next_st.term_on          = next_st.regs[1][`AMPP_OUT_TERM_BIT];
		end
	end

	// State register; reset loads constants only, straps settle through the synchronisers
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			st             <= '0;
			st.phase       <= AMPP_IDLE;
			st.sync1       <= 5'h1F;
			st.sync2       <= 5'h1F;
			st.sync3       <= 5'h1F;
			st.filt        <= 5'h1F;
			st.regs        <= {4{`AMPP_REG_RESET}};
		end else begin
			st <= next_st;
		end
	end

	// Open drain: value is always low, only the enable moves
	assign o_sdo              = 1'b0;
	assign o_sdo_oe           = st.sdo_pull;
	assign o_serial_mode      = st.serial_mode;
	assign o_two_lane         = st.two_lane;
	assign o_lvds_low_current = st.lvds_low_current;
	assign o_sleep            = st.sleep;
	assign o_term_on          = st.term_on;
	assign o_soft_reset       = st.reset_bit;
	assign o_regs             = st.regs;

endmodule : ampp_port

/* File: pkg/ampp_consts.svh */
`ifndef AMPP_CONSTS_SVH
`define AMPP_CONSTS_SVH

// Serial word layout
`define AMPP_WORD_BITS      5'h10
`define AMPP_RW_POS         15
`define AMPP_ADDR_MSB       14
`define AMPP_ADDR_LSB       8
`define AMPP_DATA_MSB       7
`define AMPP_DATA_LSB       0
`define AMPP_ADDR_PHASE_END 5'h07
`define AMPP_LAST_OUT_EDGE  5'h0F

// Register offsets (7-bit address space)
`define AMPP_OFS_SOFT_RESET 7'h00
`define AMPP_OFS_FORMAT     7'h01
`define AMPP_OFS_OUTPUT     7'h02
`define AMPP_OFS_TP_MSB     7'h03
`define AMPP_OFS_TP_LSB     7'h04

// Field positions
`define AMPP_SOFT_RESET_BIT 7
`define AMPP_FMT_SLEEP_BIT  4
`define AMPP_OUT_TERM_BIT   4
`define AMPP_OUT_ILVDS_MSB  7
`define AMPP_OUT_ILVDS_LSB  5
`define AMPP_OUT_MODE_MSB   2
`define AMPP_OUT_MODE_LSB   0

// Field encodings
`define AMPP_ILVDS_1P75MA   3'h7
`define AMPP_MODE_2L_LAST   3'h2

// Reset and unmapped read values
`define AMPP_REG_RESET      8'h00
`define AMPP_UNMAPPED_READ  8'h00

// Pin synchroniser slots
`define AMPP_PIN_SEL        0
`define AMPP_PIN_CS         1
`define AMPP_PIN_SCK        2
`define AMPP_PIN_SDI        3
`define AMPP_PIN_SDO        4
`define AMPP_PIN_COUNT      5

`endif

/* File: pkg/ampp_pkg.sv */
package ampp_pkg;

	typedef enum logic [1:0] {
		AMPP_IDLE  = 2'b00,
		AMPP_SHIFT = 2'b01
	} ampp_phase_e;

	typedef logic [3:0][7:0] ampp_regs_t;

	typedef struct packed {
		logic [4:0]  sync1;
		logic [4:0]  sync2;
		logic [4:0]  sync3;
		logic [4:0]  filt;
		ampp_phase_e phase;
		logic [4:0]  bit_cnt;
		logic [15:0] shift_in;
		logic [7:0]  shift_out;
		logic        rd;
		logic        sdo_pull;
		ampp_regs_t  regs;
		logic        reset_bit;
		logic        serial_mode;
		logic        two_lane;
		logic        lvds_low_current;
		logic        sleep;
		logic        term_on;
	} ampp_state_s;

endpackage : ampp_pkg

/* File: tb/ampp_host.sv */
`timescale 1ns/1ps
// Serial master; sck rests low between frames
module ampp_host (
	input  wire logic i_core_clk,
	input  wire logic i_wire,
	output logic      o_cs_n,
	output logic      o_sck,
	output logic      o_sdi
);
	initial begin
		o_cs_n = 1'b1;
		o_sck  = 1'b0;
		o_sdi  = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(negedge i_core_clk);
	endtask : hold
	// Static levels for strap mode
	task automatic pins(input logic c, input logic k, input logic d);
		hold(1);
		o_cs_n = c;
		o_sck  = k;
		o_sdi  = d;
	endtask : pins
	// Data moves mid low phase, clear of the device's delayed sampling
	task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] rd);
		int i;
		rd = 8'h00;
		hold(1);
		o_cs_n = 1'b0;
		for (i = 0; i < n; i++) begin
			hold(2);
			o_sdi = (i < 16) ? w[15 - i] : ~o_sdi;
			hold(2);
			if (i > 7 && i < 16) rd[15 - i] = i_wire;
			o_sck = 1'b1;
			hold(4);
			o_sck = 1'b0;
		end
		hold(4);
		o_cs_n = 1'b1;
		o_sdi  = ~o_sdi; // Stale data must not look valid
		hold(8);
	endtask : xfer
endmodule : ampp_host

/* File: tb/ampp_monitor.sv */
`timescale 1ns/1ps
module ampp_monitor (
	input wire logic            i_core_clk,
	input wire logic            i_reset,
	input wire logic            i_port_style_select,
	input wire logic            i_cs_n,
	input wire logic            i_sck,
	input wire logic            i_sdi,
	input wire logic            i_sdo,
	input wire logic            o_sdo,
	input wire logic            o_sdo_oe,
	input wire logic            o_serial_mode,
	input wire logic            o_two_lane,
	input wire logic            o_lvds_low_current,
	input wire logic            o_sleep,
	input wire logic            o_term_on,
	input wire logic            o_soft_reset,
	input ampp_pkg::ampp_regs_t o_regs
);
	import ampp_pkg::*;
	// Eight cycles of a steady pin cover the synchroniser delay
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_reset);
	AST_SDO_LOW: assert property (o_sdo == 1'b0)
		else $error("sdo value not low");
	AST_SER_MODE: assert property (!i_port_style_select [*6] |=> o_serial_mode)
		else $error("serial mode missing");
	AST_TWO_LANE: assert property ((i_port_style_select && i_cs_n) [*8] |=> !o_two_lane)
		else $error("lane strap wrong");
	AST_LVDS: assert property ((i_port_style_select && i_sck) [*8] |=> o_lvds_low_current)
		else $error("current strap wrong");
	AST_SLEEP: assert property ((i_port_style_select && i_sdi) [*8] |=> o_sleep)
		else $error("sleep strap wrong");
	AST_TERM: assert property ((i_port_style_select && !i_sdo) [*8] |=> !o_term_on)
		else $error("termination strap wrong");
	AST_SRST_PULSE: assert property (o_soft_reset |=> !o_soft_reset)
		else $error("reset pulse too long");
	AST_SRST_CLEAR: assert property (o_soft_reset |-> ##[0:1] o_regs == 32'h0)
		else $error("registers not cleared");
	AST_SRST_SLEEP: assert property (o_soft_reset |-> ##[0:1] o_sleep)
		else $error("no sleep on reset");
	AST_SDO_IDLE: assert property (i_cs_n [*8] |-> !o_sdo_oe)
		else $error("sdo held outside frame");
endmodule : ampp_monitor

/* File: tb/ampp_port_tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
	$display("wrong value at %0t got %h expected %h", $time, g, e); end end
module ampp_port_tb;
	import ampp_pkg::*;
	logic        i_core_clk = 1'b0;
	logic        i_reset = 1'b1;
	logic        i_port_style_select = 1'b1;
	logic        strap_sdo = 1'b1;
	wire logic   i_cs_n, i_sck, i_sdi, i_sdo;
	logic        o_sdo, o_sdo_oe, o_serial_mode, o_two_lane;
	logic        o_lvds_low_current, o_sleep, o_term_on, o_soft_reset;
	ampp_regs_t  o_regs;
	int          n_mismatch = 0, cmp_count = 0, n_srst = 0, k, a;
	int          mdl[6];
	logic [31:0] seed = 32'h526F;
	logic [31:0] r;
	logic [7:0]  rd;
	always #25 i_core_clk = ~i_core_clk;
	// Pull-up wins when the device releases the wire
	assign i_sdo = o_sdo_oe ? o_sdo : strap_sdo;
	always @(posedge i_core_clk) if (o_soft_reset === 1'b1) n_srst++;
	ampp_port u_ampp_port (.*);
	ampp_host u_host (.i_core_clk(i_core_clk), .i_wire(i_sdo), .o_cs_n(i_cs_n),
		.o_sck(i_sck), .o_sdi(i_sdi));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [31:0] exp_regs();
		return {8'(mdl[4]), 8'(mdl[3]), 8'(mdl[2]), 8'(mdl[1])};
	endfunction : exp_regs
	task automatic tally_and_finish();
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : tally_and_finish
	// Low reset bits are noise and must not matter
	task automatic srst();
		r = rnd();
		u_host.xfer({9'h001, r[6:0]}, 16, rd);
		foreach (mdl[i]) mdl[i] = 0;
		`CHK(o_regs, 32'h0)
	endtask : srst
	initial begin
		#1000000;
		n_mismatch++;
		tally_and_finish();
	end
	initial begin
		repeat (5) @(posedge i_core_clk);
		@(negedge i_core_clk);
		i_reset = 1'b0;
		for (k = 0; k < 12; k++) begin
			r = rnd();
			u_host.pins(r[0], r[1], r[2]);
			strap_sdo = r[3];
			u_host.hold(8);
			`CHK({o_serial_mode, o_two_lane, o_lvds_low_current, o_sleep, o_term_on},
				{1'b0, ~r[0], r[1], r[2], r[3]})
		end
		u_host.pins(1'b1, 1'b0, 1'b0);
		strap_sdo = 1'b1;
		i_port_style_select = 1'b0;
		u_host.hold(10);
		`CHK(o_serial_mode, 1'b1)
		srst();
		// Address 55h stands for an unmapped place; one frame has extra clocks
		for (a = 1; a < 6; a++) begin
			r = rnd();
			if (a < 5) mdl[a] = r[7:0];
			u_host.xfer({1'b0, (a < 5) ? 7'(a) : 7'h55, r[7:0]}, (a == 3) ? 20 : 16, rd);
			`CHK(o_regs, exp_regs())
		end
		// Serial-mode outputs follow the written register fields
		`CHK({o_two_lane, o_lvds_low_current, o_sleep, o_term_on}, {1'((mdl[2] & 7) <= 2), 1'(((mdl[2] >> 5) & 7) == 7), 1'(mdl[1] >> 4), 1'(mdl[2] >> 4)})
		for (a = 0; a < 6; a++) begin
			r = rnd();
			u_host.xfer({1'b1, (a < 5) ? 7'(a) : 7'h55, r[7:0]}, 16, rd);
			`CHK(rd, (a > 0 && a < 5) ? 8'(mdl[a]) : 8'h00)
			`CHK(o_regs, exp_regs())
		end
		srst();
		`CHK(n_srst, 2)
		tally_and_finish();
	end
endmodule : ampp_port_tb
bind ampp_port ampp_monitor u_mon (.*);
